//--- rtl/ccc_cfg_pkg.sv
package ccc_cfg_pkg;
  localparam int CFG_W = 81;
  localparam int DIV_CODE_W = 7;
  localparam int OUT_CODE_W = 5;

  // 81-bit configuration word, shifted in bit 0 first
  typedef struct packed {
    logic       resync_en;
    logic [2:0] dyn_input_sel;
    logic [2:0] vco_gear;
    logic [2:0] static_input_sel;
    logic [4:0] dly_sec2_local;
    logic [4:0] dly_sec1_local;
    logic [4:0] dly_sec2_global;
    logic [4:0] dly_sec1_global;
    logic [4:0] dly_primary;
    logic       sys_delay_sel;
    logic [4:0] fb_delay;
    logic [1:0] feedback_path_select;
    logic [2:0] secondary2_phase_select;
    logic [2:0] secondary1_phase_select;
    logic [2:0] spare;
    logic [4:0] out_div_sec2;
    logic [4:0] out_div_sec1;
    logic [4:0] out_div_primary;
    logic [6:0] fb_div;
    logic [6:0] in_div;
  } pll_cfg_t;

  // Decoded controls handed to the analog core
  typedef struct packed {
    logic [7:0]        in_factor;
    logic [7:0]        fb_factor;
    logic [5:0]        out_factor_primary;
    logic [5:0]        out_factor_sec1;
    logic [5:0]        out_factor_sec2;
    logic [12:0]       den_primary;
    logic [12:0]       den_sec1;
    logic [12:0]       den_sec2;
    logic [8:0]        phase_sec1_deg;
    logic [8:0]        phase_sec2_deg;
    logic              ext_feedback;
    logic [15:0]       fb_advance_ps;
    logic signed [15:0] net_primary_ps;
    logic signed [15:0] net_sec1_global_ps;
    logic signed [15:0] net_sec2_global_ps;
    logic signed [15:0] net_sec1_local_ps;
    logic signed [15:0] net_sec2_local_ps;
  } ccc_ctrl_t;

  localparam logic [1:0] FB_SEL_NONE = 2'h0;
  localparam logic [1:0] FB_SEL_PROG = 2'h1;
  localparam logic [1:0] FB_SEL_EXT  = 2'h2;

  localparam int SYS_DELAY_PS     = 2000;
  localparam int FB_DLY_MIN_PS    = 600;
  localparam int FB_DLY_STEP_PS   = 160;
  localparam int GL_DLY_STEP_PS   = 200;
  localparam int GL_DLY_END_PS    = 6735;
  localparam int GL_DRIVER_PS     = 755;
  localparam int DLY_CODE_MAX     = 31;
  localparam int PHASE_STEP_DEG   = 90;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ACT0   = 8'h08;
  localparam logic [7:0] ADDR_ACT1   = 8'h0C;
  localparam logic [7:0] ADDR_ACT2   = 8'h10;
  localparam logic [7:0] ADDR_SHF0   = 8'h14;
  localparam logic [7:0] ADDR_SHF1   = 8'h18;
  localparam logic [7:0] ADDR_SHF2   = 8'h1C;
  localparam logic [7:0] ADDR_REFA   = 8'h20;
  localparam logic [7:0] ADDR_REFB   = 8'h24;
  localparam logic [7:0] ADDR_REFC   = 8'h28;

  localparam int CTRL_SRC_BIT    = 0;
  localparam int ST_SEN_BIT      = 0;
  localparam int ST_SRC_BIT      = 1;
  localparam int ST_RESYNC_BIT   = 2;
  localparam int ST_COUNT_LSB    = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : ccc_cfg_pkg

//--- rtl/pll_ccc_dynamic_config.sv
`timescale 1ns/1ps
`default_nettype none
module pll_ccc_dynamic_config
  import ccc_cfg_pkg::*;
#(
  parameter logic [CFG_W-1:0] FLASH_CFG = 81'h0,
  parameter int               REF_CNT_W = 16
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          ref_clock_a,
  input  wire logic          ref_clock_b,
  input  wire logic          ref_clock_c,
  input  wire logic          cfg_serial_in,
  input  wire logic          cfg_shift_clock,
  input  wire logic          cfg_shift_enable,
  input  wire logic          cfg_apply_strobe,
  output logic               cfg_serial_out,
  output logic               divider_resync,
  output pll_cfg_t           active_cfg,
  output ccc_ctrl_t          ccc_ctrl
);
  if (REF_CNT_W < 4 || REF_CNT_W > 32) begin : g_bad_ref_cnt_w
    $error("REF_CNT_W must lie in 4..32");
  end

  localparam int NSYNC = 7;
  // Bit order of the synchronised pin bundle
  localparam int S_DIN = 0;
  localparam int S_CLK = 1;
  localparam int S_SEN = 2;
  localparam int S_UPD = 3;
  localparam int S_RFA = 4;

  // Pins from other domains: two flops before any logic looks at them
  logic [NSYNC-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [NSYNC-1:0] pins;
  assign pins = {ref_clock_c, ref_clock_b, ref_clock_a, cfg_apply_strobe,
                 cfg_shift_enable, cfg_shift_clock, cfg_serial_in};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic shift_edge, apply_pulse;
  // Strobe is ignored while shifting so a stray high cannot commit a half word
  assign shift_edge  = sync2_reg[S_CLK] & ~prev_reg[S_CLK]
                     & sync2_reg[S_SEN];
  assign apply_pulse = sync2_reg[S_UPD] & ~prev_reg[S_UPD]
                     & ~sync2_reg[S_SEN];

  // Shift register, dynamic copy, bit counter
  logic [CFG_W-1:0] shift_reg, shift_next;
  pll_cfg_t         dyn_reg, dyn_next;
  logic [7:0]       count_reg, count_next;
  logic             resync_reg, resync_next;
  logic             seen_resync_reg, seen_resync_next;
  logic             src_reg;

  always_comb begin
    shift_next       = shift_reg;
    dyn_next         = dyn_reg;
    count_next       = count_reg;
    resync_next      = 1'b0;
    seen_resync_next = seen_resync_reg;
    if (shift_edge) begin
      shift_next = {sync2_reg[S_DIN], shift_reg[CFG_W-1:1]};
      if (count_reg != 8'hFF) begin
        count_next = count_reg + 8'h01;
      end
    end
    if (apply_pulse) begin
      dyn_next   = pll_cfg_t'(shift_reg);
      count_next = 8'h00;
      if (shift_reg[CFG_W-1]) begin
        resync_next      = 1'b1;
        seen_resync_next = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg       <= '0;
      dyn_reg         <= FLASH_CFG;
      count_reg       <= 8'h00;
      resync_reg      <= 1'b0;
      seen_resync_reg <= 1'b0;
    end else begin
      shift_reg       <= shift_next;
      dyn_reg         <= dyn_next;
      count_reg       <= count_next;
      resync_reg      <= resync_next;
      seen_resync_reg <= seen_resync_next;
    end
  end

  assign cfg_serial_out = shift_reg[0];
  assign divider_resync = resync_reg;

  // Flash bits are a parameter, so nothing at run time can alter them
  pll_cfg_t sel_cfg;
  assign sel_cfg = src_reg ? dyn_reg : pll_cfg_t'(FLASH_CFG);

  // Reference clock edge counters, one per input
  logic [REF_CNT_W-1:0] ref_cnt_reg [3];
  logic [REF_CNT_W-1:0] ref_cnt_next [3];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ref
      always_comb begin
        ref_cnt_next[gi] = ref_cnt_reg[gi];
        if (sync2_reg[S_RFA+gi] & ~prev_reg[S_RFA+gi]) begin
          ref_cnt_next[gi] = ref_cnt_reg[gi] + 1'b1;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ref_cnt_reg[gi] <= '0;
        end else begin
          ref_cnt_reg[gi] <= ref_cnt_next[gi];
        end
      end
    end
  endgenerate

  // Decode of the selected configuration
  function automatic logic signed [15:0] local_ps(input logic [4:0] c);
    local_ps = 16'(FB_DLY_MIN_PS) + 16'(FB_DLY_STEP_PS) * 16'(c);
  endfunction
  function automatic logic signed [15:0] global_ps(input logic [4:0] c);
    global_ps = 16'(GL_DRIVER_PS) + 16'(GL_DLY_END_PS)
              - 16'(GL_DLY_STEP_PS) * (16'(DLY_CODE_MAX) - 16'(c));
  endfunction
  function automatic logic [8:0] phase_deg(input logic [2:0] c);
    phase_deg = 9'(PHASE_STEP_DEG) * 9'(c[1:0]);
  endfunction

  ccc_ctrl_t ctrl_next;
  logic [15:0] adv;
  always_comb begin
    ctrl_next = '0;
    // Stored code is factor minus one, so every code is a legal factor
    ctrl_next.in_factor          = {1'b0, sel_cfg.in_div} + 8'h01;
    ctrl_next.fb_factor          = {1'b0, sel_cfg.fb_div} + 8'h01;
    ctrl_next.out_factor_primary = {1'b0, sel_cfg.out_div_primary} + 6'h01;
    ctrl_next.out_factor_sec1    = {1'b0, sel_cfg.out_div_sec1} + 6'h01;
    ctrl_next.out_factor_sec2    = {1'b0, sel_cfg.out_div_sec2} + 6'h01;
    // Paired global and local outputs share one denominator
    // Widen before multiplying: 128 times 32 does not fit in eight bits
    ctrl_next.den_primary = 13'(ctrl_next.in_factor)
                          * 13'(ctrl_next.out_factor_primary);
    ctrl_next.den_sec1    = 13'(ctrl_next.in_factor)
                          * 13'(ctrl_next.out_factor_sec1);
    ctrl_next.den_sec2    = 13'(ctrl_next.in_factor)
                          * 13'(ctrl_next.out_factor_sec2);
    ctrl_next.phase_sec1_deg = phase_deg(sel_cfg.secondary1_phase_select);
    ctrl_next.phase_sec2_deg = phase_deg(sel_cfg.secondary2_phase_select);
    ctrl_next.ext_feedback = (sel_cfg.feedback_path_select == FB_SEL_EXT);
    adv = 16'h0000;
    if (sel_cfg.sys_delay_sel) begin
      adv = 16'(SYS_DELAY_PS);
    end
    if (sel_cfg.feedback_path_select == FB_SEL_PROG) begin
      adv = adv + 16'(local_ps(sel_cfg.fb_delay));
    end
    ctrl_next.fb_advance_ps = adv;
    // Feedback delay subtracts from every output delay
    ctrl_next.net_primary_ps     = global_ps(sel_cfg.dly_primary) - $signed(adv);
    ctrl_next.net_sec1_global_ps = global_ps(sel_cfg.dly_sec1_global) - $signed(adv);
    ctrl_next.net_sec2_global_ps = global_ps(sel_cfg.dly_sec2_global) - $signed(adv);
    ctrl_next.net_sec1_local_ps  = local_ps(sel_cfg.dly_sec1_local) - $signed(adv);
    ctrl_next.net_sec2_local_ps  = local_ps(sel_cfg.dly_sec2_local) - $signed(adv);
    // Input mux bits 71-73 and 77-79 are routed elsewhere and not decoded
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ccc_ctrl   <= '0;
      active_cfg <= '0;
    end else begin
      ccc_ctrl   <= ctrl_next;
      active_cfg <= sel_cfg;
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  logic        aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        src_next;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [CFG_W-1:0] act_bits;
  assign act_bits = dyn_reg;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_CTRL:   rd_word[CTRL_SRC_BIT] = src_reg;
      ADDR_STATUS: begin
        rd_word[ST_SEN_BIT]    = sync2_reg[S_SEN];
        rd_word[ST_SRC_BIT]    = src_reg;
        rd_word[ST_RESYNC_BIT] = seen_resync_reg;
        rd_word[ST_COUNT_LSB +: 8] = count_reg;
      end
      ADDR_ACT0:   rd_word = act_bits[31:0];
      ADDR_ACT1:   rd_word = act_bits[63:32];
      ADDR_ACT2:   rd_word[CFG_W-65:0] = act_bits[CFG_W-1:64];
      ADDR_SHF0:   rd_word = shift_reg[31:0];
      ADDR_SHF1:   rd_word = shift_reg[63:32];
      ADDR_SHF2:   rd_word[CFG_W-65:0] = shift_reg[CFG_W-1:64];
      ADDR_REFA:   rd_word[REF_CNT_W-1:0] = ref_cnt_reg[0];
      ADDR_REFB:   rd_word[REF_CNT_W-1:0] = ref_cnt_reg[1];
      ADDR_REFC:   rd_word[REF_CNT_W-1:0] = ref_cnt_reg[2];
      default:     rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    src_next     = src_reg;
    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_full_reg && w_full_reg && !bvalid_reg) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      if (awaddr_reg == ADDR_CTRL) begin
        if (wstrb_reg[0]) begin
          src_next = wdata_reg[CTRL_SRC_BIT];
        end
      end else if (awaddr_reg != ADDR_STATUS && awaddr_reg > ADDR_REFC) begin
        bresp_next = RESP_DECERR;
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_word;
      rresp_next  = rd_hit ? RESP_OKAY : RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= 2'h0;
      rdata_reg   <= 32'h0000_0000;
      src_reg     <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      src_reg     <= src_next;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SHIFT_IN_TOP: assert property (shift_edge |=> shift_reg[CFG_W-1] == $past(sync2_reg[S_DIN])) else $error("serial bit not in top");
  AST_SHIFT_OUT_LSB: assert property (shift_edge |=> cfg_serial_out == $past(shift_reg[1])) else $error("serial out not next bit");
  AST_HOLD_NO_SHIFT: assert property (!sync2_reg[S_SEN] |=> $stable(shift_reg)) else $error("shift without enable");
  AST_APPLY_COMMIT: assert property (apply_pulse |=> dyn_reg == $past(shift_reg)) else $error("update not committed");
  AST_STATIC_SRC: assert property (!src_reg |=> active_cfg == $past(pll_cfg_t'(FLASH_CFG))) else $error("static source wrong");
  AST_DYN_SRC: assert property (src_reg && $stable(dyn_reg) |=> active_cfg == $past(dyn_reg)) else $error("dynamic source wrong");
  AST_IN_DIV_RANGE: assert property ($past(aresetn) |-> ccc_ctrl.in_factor - 8'h01 == {1'b0, $past(sel_cfg.in_div)} && ccc_ctrl.fb_factor >= 8'h01 && ccc_ctrl.fb_factor <= 8'h80) else $error("input divider out of range");
  AST_OUT_DIV_RANGE: assert property ($past(aresetn) |-> ccc_ctrl.out_factor_primary - 6'h01 == {1'b0, $past(sel_cfg.out_div_primary)} && ccc_ctrl.out_factor_sec2 >= 6'h01 && ccc_ctrl.out_factor_sec2 <= 6'h20) else $error("output divider out of range");
  AST_RESYNC_PULSE: assert property (apply_pulse && shift_reg[CFG_W-1] |=> divider_resync ##1 !divider_resync) else $error("resync pulse wrong");
  AST_NO_FB_DELAY: assert property (sel_cfg.feedback_path_select == FB_SEL_NONE && !sel_cfg.sys_delay_sel |=> ccc_ctrl.fb_advance_ps == 16'h0000) else $error("bypass has delay");
endmodule // pll_ccc_dynamic_config
`default_nettype wire

//--- tb/cfg_loader_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_model
  import ccc_cfg_pkg::*;
(
  output logic serial_in,
  output logic shift_clock,
  output logic shift_enable,
  output logic apply_strobe
);
  initial begin
    serial_in    = 1'b0;
    shift_clock  = 1'b0;
    shift_enable = 1'b0;
    apply_strobe = 1'b0;
  end

  // Clock pulses n times with enable held at en, strobe held low while shifting
  task automatic shift_bits(input logic [CFG_W-1:0] word, input int n,
                            input logic en);
    int i;
    #23;
    shift_enable = en;
    for (i = 0; i < n; i++) begin
      serial_in = word[i];
      #200;
      shift_clock = 1'b1;
      #200;
      shift_clock = 1'b0;
    end
    #200;
    shift_enable = 1'b0;
    // Released data line must not keep its last value
    serial_in = ~serial_in;
  endtask

  // Strobe only once enable is low, then back low until next update
  task automatic commit();
    // Keep the strobe edge away from the system clock edge
    #23;
    #400;
    apply_strobe = 1'b1;
    #400;
    apply_strobe = 1'b0;
    #400;
  endtask
endmodule // cfg_loader_model
`default_nettype wire

//--- tb/tb_pll_ccc_dynamic_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pll_ccc_dynamic_config;
  import ccc_cfg_pkg::*;
  localparam logic [CFG_W-1:0] FLASH_W = 81'h0_0A5A_5C3C_F00F_1234_5678;
  logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, rd;
  logic [1:0]       bresp, rresp, rs;
  logic             ref_a, ref_b, ref_c, sin, sclk, sen, sup, sout, resync;
  logic [CFG_W-1:0] got;
  pll_cfg_t         act;
  pll_cfg_t         w [2];
  ccc_ctrl_t        ctrl;
  int               failures, checks, resyncs, i;

  pll_ccc_dynamic_config #(.FLASH_CFG(FLASH_W), .REF_CNT_W(16)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ref_clock_a(ref_a), .ref_clock_b(ref_b), .ref_clock_c(ref_c),
    .cfg_serial_in(sin), .cfg_shift_clock(sclk), .cfg_shift_enable(sen),
    .cfg_apply_strobe(sup), .cfg_serial_out(sout),
    .divider_resync(resync), .active_cfg(act), .ccc_ctrl(ctrl));

  cfg_loader_model loader_u (.serial_in(sin), .shift_clock(sclk),
    .shift_enable(sen), .apply_strobe(sup));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (resync === 1'b1) resyncs++;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [CFG_W-1:0] g, input logic [CFG_W-1:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic hang();
    failures++;
    $display("[ERR] %0t no answer", $time);
    stop_test();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !(bvalid === 1'b1 && bready); n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    if (n == 50) hang();
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !(rvalid === 1'b1 && rready); n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    if (n == 50) hang();
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_shift();
    axi_rd(ADDR_SHF0);
    got[31:0] = rd;
    axi_rd(ADDR_SHF1);
    got[63:32] = rd;
    axi_rd(ADDR_SHF2);
    got[80:64] = rd[16:0];
  endtask

  function automatic pll_cfg_t mk(input logic [6:0] ind, input logic [4:0] od,
      input logic [2:0] ph, input logic [1:0] fbs, input logic rsy);
    pll_cfg_t c;
    c = '0;
    c.in_div = ind;
    c.fb_div = 7'h7F - ind;
    c.out_div_primary = od;
    c.fb_delay = od;
    c.secondary1_phase_select = ph;
    c.secondary2_phase_select = ph + 3'h2;
    c.feedback_path_select = fbs;
    c.resync_en = rsy;
    return c;
  endfunction

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {ref_a, ref_b, ref_c, awaddr, araddr, wdata} = '0;
    {failures, checks, resyncs} = '0;
    w[0] = mk(7'h7F, 5'h1F, 3'h1, FB_SEL_EXT, 1'b1);
    w[1] = mk(7'h00, 5'h00, 3'h6, FB_SEL_PROG, 1'b0);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check(act, FLASH_W);
    check(CFG_W'(ctrl.ext_feedback), '0);
    axi_rd(8'h40);
    check(CFG_W'(rs), CFG_W'(RESP_DECERR));
    for (i = 0; i < 7; i++) begin
      repeat (4) @(posedge aclk);
      ref_a <= (i < 3);
      ref_b <= (i < 5);
      ref_c <= 1'b1;
      repeat (4) @(posedge aclk);
      {ref_a, ref_b, ref_c} <= 3'h0;
    end
    repeat (4) @(posedge aclk);
    axi_rd(ADDR_REFA);
    check(CFG_W'(rd), 81'h3);
    axi_rd(ADDR_REFB);
    check(CFG_W'(rd), 81'h5);
    axi_rd(ADDR_REFC);
    check(CFG_W'(rd), 81'h7);
    axi_wr(ADDR_CTRL, 32'h1);
    axi_rd(ADDR_STATUS);
    check(CFG_W'(rd[ST_SRC_BIT]), 81'h1);
    for (i = 0; i < 2; i++) begin
      loader_u.shift_bits(w[i], CFG_W, 1'b1);
      rd_shift();
      check(got, w[i]);
      check(CFG_W'(sout), CFG_W'(w[i][0]));
      check(act, i == 0 ? FLASH_W : w[0]);
      loader_u.commit();
      @(posedge aclk);
      check(act, w[i]);
      check(CFG_W'(ctrl.in_factor), CFG_W'(w[i].in_div) + 1);
      check(CFG_W'(ctrl.fb_factor), CFG_W'(w[i].fb_div) + 1);
      check(CFG_W'(ctrl.out_factor_primary),
            CFG_W'(w[i].out_div_primary) + 1);
      check(CFG_W'(ctrl.den_primary), CFG_W'((w[i].in_div + 1)
            * (w[i].out_div_primary + 1)));
      check(CFG_W'(ctrl.fb_advance_ps), CFG_W'((w[i].feedback_path_select
            == FB_SEL_PROG) ? FB_DLY_MIN_PS
            + FB_DLY_STEP_PS * w[i].fb_delay : 0));
      check(CFG_W'(ctrl.phase_sec1_deg), CFG_W'(PHASE_STEP_DEG
            * w[i].secondary1_phase_select[1:0]));
      check(CFG_W'(ctrl.phase_sec2_deg), CFG_W'(PHASE_STEP_DEG
            * w[i].secondary2_phase_select[1:0]));
      check(CFG_W'(ctrl.ext_feedback),
            CFG_W'(w[i].feedback_path_select == FB_SEL_EXT));
      check(CFG_W'(resyncs), 81'h1);
    end
    loader_u.shift_bits(81'h1, 8, 1'b0);
    rd_shift();
    check(got, w[1]);
    axi_wr(ADDR_CTRL, 32'h0);
    repeat (4) @(posedge aclk);
    check(act, FLASH_W);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    hang();
  end
endmodule // tb_pll_ccc_dynamic_config
`default_nettype wire
